// ===== hw/dalc_lamp.sv
// drive activity lamp control: apb registers, lamp decision and the
// open-drain lamp pin
// assumes drive condition inputs come from logic on core_clk and that
// the lamp pin is pulled up outside through an led and resistor
//
// Contract
// - One software bit chooses between the two activity meanings.
// - Spindle stopped and no command keeps the lamp dark.
// - Spindle stopped with a command executing lights the lamp.
// - At speed and idle, lamp lit for bit 0 and dark for bit 1.
// - At speed and busy, lamp dark for bit 0 and lit for bit 1.
// - Spinning up or down blinks 0.5 s lit and 0.5 s dark.
// - During format, unless spinning up or down, the lamp inverts at every cylinder change.
// - Lit means pin driven low, dark means pin released.
`include "dalc_cfg.svh"

module dalc_lamp import dalc_pkg::*; #(
    parameter int unsigned BLINK_HALF_CYCLES = `DALC_BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire dalc_apb_req_t apb_req,
    output dalc_apb_rsp_t apb_rsp,
    // drive condition
    input wire dalc_drv_t drv,
    // open-drain lamp pin
    input wire logic status_lamp_drive_n_i,
    output logic status_lamp_drive_n_o,
    output logic status_lamp_drive_n_oe
);

    // ****************************************************************
    // declarations
    // ****************************************************************

    logic lamp_sense_select_q;
    logic lamp_on_q;
    logic lamp_on_d;
    logic table_on;
    logic spinning;
    logic blink_lit;
    logic blink_tick;
    logic pin_meta_q;
    logic pin_sync_q;
    logic [`DALC_TOG_W-1:0] toggles_q;
    logic [31:0] rdata_q;
    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_status;
    logic hit_toggles;
    logic unmapped;
    logic [31:0] rd_word;

    // ****************************************************************
    // apb slave
    // ****************************************************************

    assign setup_ph = apb_req.psel && !apb_req.penable;
    assign access_ph = apb_req.psel && apb_req.penable;

    // address decode
    always_comb begin
        hit_ctrl = 1'b0;
        hit_status = 1'b0;
        hit_toggles = 1'b0;
        if (apb_req.paddr == `DALC_OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (apb_req.paddr == `DALC_OFS_STATUS) begin
            hit_status = 1'b1;
        end else if (apb_req.paddr == `DALC_OFS_TOGGLES) begin
            hit_toggles = 1'b1;
        end
    end

    assign unmapped = !(hit_ctrl || hit_status || hit_toggles);

    // read word, unused bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_word[`DALC_CTRL_SENSE_BIT] = lamp_sense_select_q;
        end else if (hit_status) begin
            rd_word[`DALC_ST_LAMP_BIT] = lamp_on_q;
            rd_word[`DALC_ST_PIN_LOW_BIT] = !pin_sync_q;
            rd_word[`DALC_ST_SPIN_MSB:`DALC_ST_SPIN_LSB] = drv.spindle;
            rd_word[`DALC_ST_CMD_BIT] = drv.cmd_active;
            rd_word[`DALC_ST_FMT_BIT] = drv.format_active;
            rd_word[`DALC_ST_BLINK_BIT] = blink_lit;
        end else if (hit_toggles) begin
            rd_word[`DALC_TOG_W-1:0] = toggles_q;
        end
    end

    // read data is captured in the setup phase so the access phase can
    // finish with no wait state and prdata still comes from a flop
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_ph && !apb_req.pwrite) begin
            rdata_q <= rd_word;
        end
    end

    // zero wait states; error only for an unmapped word
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_ph && unmapped;
    assign apb_rsp.prdata = rdata_q;

    // ****************************************************************
    // configuration
    // ****************************************************************

    always_ff @(posedge core_clk) begin
        if (reset) begin
            lamp_sense_select_q <= `DALC_CTRL_RST;
        end else if (access_ph && apb_req.pwrite && hit_ctrl) begin
            lamp_sense_select_q <= apb_req.pwdata[`DALC_CTRL_SENSE_BIT];
        end
    end

    // ****************************************************************
    // pin readback
    // ****************************************************************

    // the pin level comes from outside, so two flops before any use
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else begin
            pin_meta_q <= status_lamp_drive_n_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ****************************************************************
    // blink timing
    // ****************************************************************

    assign spinning = (drv.spindle == spin_going_up) ||
                      (drv.spindle == spin_going_down);

    dalc_blink #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .core_clk(core_clk),
        .reset(reset),
        .run(spinning),
        .lit(blink_lit),
        .tick(blink_tick)
    );

    // ****************************************************************
    // lamp decision
    // ****************************************************************

    // activity table for a steady spindle
    always_comb begin
        table_on = 1'b0;
        case (drv.spindle)
            spin_stopped: begin
                table_on = drv.cmd_active;
            end
            // at speed: meaning bit flips sense
            spin_at_speed: begin
                table_on = drv.cmd_active ^ !lamp_sense_select_q;
            end
            default: begin
                table_on = 1'b0;
            end
        endcase
    end

    // blink first, then format toggling, then the table; format holds
    // the lamp between cylinder changes so a toggle is always visible
    always_comb begin
        lamp_on_d = table_on;
        if (spinning) begin
            lamp_on_d = blink_lit;
        end else if (drv.format_active) begin
            lamp_on_d = drv.cyl_change ? !lamp_on_q : lamp_on_q;
        end
    end

    // lamp state flop
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lamp_on_q <= 1'b0;
        end else begin
            lamp_on_q <= lamp_on_d;
        end
    end

    // count of format toggles, wraps; a software progress aid
    always_ff @(posedge core_clk) begin
        if (reset) begin
            toggles_q <= `DALC_TOG_RST;
        end else if (!spinning && drv.format_active && drv.cyl_change) begin
            toggles_q <= toggles_q + 1'b1;
        end
    end

    // ****************************************************************
    // lamp pin
    // ****************************************************************

    // sink current to light, release to darken
    assign status_lamp_drive_n_o = 1'b0;
    assign status_lamp_drive_n_oe = lamp_on_q;

    // ****************************************************************
    // checks
    // ****************************************************************

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (reset);

    logic spin_prev_q;

    // spindle transition history for the blink entry check
    always_ff @(posedge core_clk) begin
        if (reset) begin
            spin_prev_q <= 1'b0;
        end else begin
            spin_prev_q <= spinning;
        end
    end

    sequence s_steady_quiet;
        !spinning && !drv.format_active;
    endsequence

    sequence s_spin_enter;
        spinning && !spin_prev_q;
    endsequence

    sequence s_fmt_step;
        !spinning && drv.format_active && drv.cyl_change;
    endsequence

    a_sense_write: assert property (
        (access_ph && apb_req.pwrite && hit_ctrl) |=>
        lamp_sense_select_q == $past(apb_req.pwdata[0]))
        else $error("meaning bit not taken from write");

    a_dark_stopped: assert property (
        (s_steady_quiet and drv.spindle == spin_stopped &&
         !drv.cmd_active) |=> !lamp_on_q)
        else $error("lamp lit while stopped and idle");

    a_lit_stopped: assert property (
        (s_steady_quiet and drv.spindle == spin_stopped &&
         drv.cmd_active) |=> lamp_on_q)
        else $error("lamp dark while stopped and busy");

    a_ready_idle: assert property (
        (s_steady_quiet and drv.spindle == spin_at_speed &&
         !drv.cmd_active) |=> lamp_on_q == !$past(lamp_sense_select_q))
        else $error("wrong lamp at speed and idle");

    a_ready_busy: assert property (
        (s_steady_quiet and drv.spindle == spin_at_speed &&
         drv.cmd_active) |=> lamp_on_q == $past(lamp_sense_select_q))
        else $error("wrong lamp at speed and busy");

    a_blink_entry: assert property (
        s_spin_enter |=> lamp_on_q)
        else $error("blink did not start lit");

    a_blink_follow: assert property (
        (spinning && blink_tick) ##1 spinning |=>
        lamp_on_q != $past(lamp_on_q))
        else $error("lamp missed a blink phase change");

    a_fmt_toggle: assert property (
        s_fmt_step |=> lamp_on_q != $past(lamp_on_q))
        else $error("format cylinder change did not toggle");

    a_fmt_hold: assert property (
        (!spinning && drv.format_active && !drv.cyl_change) |=>
        $stable(lamp_on_q))
        else $error("lamp moved during format without a step");

    a_pin_drive: assert property (
        (lamp_on_q |-> status_lamp_drive_n_oe && !status_lamp_drive_n_o)
        and (!lamp_on_q |-> !status_lamp_drive_n_oe))
        else $error("lamp pin does not match lamp state");

    // only the mapped word moves the meaning bit
    a_apb_unmapped: assert property (
        (access_ph && unmapped) |-> apb_rsp.pslverr ##1
        $stable(lamp_sense_select_q))
        else $error("unmapped access flagged or handled wrongly");

endmodule // dalc_lamp

// ===== shared/dalc_cfg.svh
// offsets, field positions, reset values and timing counts of the
// drive activity lamp block; assumes a 10 MHz core clock
`ifndef DALC_CFG_SVH
`define DALC_CFG_SVH

// ****************************************************************
// register map (byte addresses, one aligned word each)
// ****************************************************************
`define DALC_ADDR_W 12
`define DALC_OFS_CTRL 12'h000
`define DALC_OFS_STATUS 12'h004
`define DALC_OFS_TOGGLES 12'h008

// ctrl fields and reset value
`define DALC_CTRL_SENSE_BIT 0
`define DALC_CTRL_RST 1'b0

// status fields
`define DALC_ST_LAMP_BIT 0
`define DALC_ST_PIN_LOW_BIT 1
`define DALC_ST_SPIN_LSB 2
`define DALC_ST_SPIN_MSB 3
`define DALC_ST_CMD_BIT 4
`define DALC_ST_FMT_BIT 5
`define DALC_ST_BLINK_BIT 6

// format toggle counter width and reset value
`define DALC_TOG_W 16
`define DALC_TOG_RST 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define DALC_CLK_HZ 10000000
`define DALC_BLINK_HALF_MS 500
`define DALC_BLINK_HALF_CYC \
    32'((64'd`DALC_BLINK_HALF_MS * 64'd`DALC_CLK_HZ) / 64'd1000)
`define DALC_BLINK_CNT_W 23

`endif

// ===== shared/dalc_pkg.sv
// types shared by the drive activity lamp block
// assumes dalc_cfg.svh is on the include path
`include "dalc_cfg.svh"

package dalc_pkg;

    // spindle condition as reported by the motor control logic
    typedef enum logic [1:0] {
        spin_stopped = 2'b00,
        spin_at_speed = 2'b01,
        spin_going_up = 2'b10,
        spin_going_down = 2'b11
    } dalc_spin_t;

    // drive condition, all on the core clock
    typedef struct packed {
        dalc_spin_t spindle;
        logic cmd_active;
        logic format_active;
        logic cyl_change;
    } dalc_drv_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`DALC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } dalc_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dalc_apb_rsp_t;

endpackage

// ===== hw/dalc_blink.sv
// half-second blink generator for the activity lamp
// assumes run comes from logic on core_clk
`include "dalc_cfg.svh"

module dalc_blink import dalc_pkg::*; #(
    parameter int unsigned HALF_CYCLES = `DALC_BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic run,
    // blink outputs
    output logic lit,
    output logic tick
);

    logic [`DALC_BLINK_CNT_W-1:0] cnt_q;
    logic lit_q;

    // ****************************************************************
    // divider
    // ****************************************************************

    // one-cycle enable at the end of each half period
    assign tick = run && (cnt_q == `DALC_BLINK_CNT_W'(HALF_CYCLES - 1));
    assign lit = lit_q;

    // cycle counter, parked at zero when idle so each blink run
    // starts with a full lit half
    always_ff @(posedge core_clk) begin
        if (reset || !run || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // phase flips on every tick, idle phase is lit
    always_ff @(posedge core_clk) begin
        if (reset || !run) begin
            lit_q <= 1'b1;
        end else if (tick) begin
            lit_q <= ~lit_q;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************

    logic [`DALC_BLINK_CNT_W-1:0] gap_q;

    // independent count of cycles since the phase last changed
    always_ff @(posedge core_clk) begin
        if (reset || !run || tick) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + 1'b1;
        end
    end

    a_blink_half_len: assert property (@(posedge core_clk)
        disable iff (reset)
        (run && $changed(lit_q) && $past(run)) |->
        $past(gap_q) == `DALC_BLINK_CNT_W'(HALF_CYCLES - 1))
        else $error("blink half period has wrong length");

endmodule // dalc_blink

// ===== bench/dalc_led_model.sv
// external lamp: led and resistor pulled up to the lamp supply
// assumes the block only ever sinks current on the pin
module dalc_led_model (
    // pin side of the block
    input wire logic drive_o,
    input wire logic drive_oe,
    // wire level and lamp state
    output logic pin,
    output logic lit
);
    timeunit 1ns;
    timeprecision 100ps;
    // pull-up when released
    // the resistor holds the wire high, so release never reads unknown
    assign pin = drive_oe ? drive_o : 1'b1;
    assign lit = (pin == 1'b0);
endmodule // dalc_led_model

// ===== bench/tb.sv
// bench for the activity lamp: apb master, drive condition stimulus
// assumes dalc_lamp with a short blink count and the led model
`include "dalc_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (a), (b)); end end

module tb import dalc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned HALF = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    dalc_apb_req_t apb_req = '0;
    dalc_apb_rsp_t apb_rsp;
    dalc_drv_t drv = '0;
    logic pin, lit, lamp_o, lamp_oe;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;

    // ****************************************************************
    // design, lamp and clock
    // ****************************************************************
    dalc_lamp #(.BLINK_HALF_CYCLES(HALF)) dalc_lamp_inst (
        .core_clk(core_clk), .reset(reset), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .drv(drv), .status_lamp_drive_n_i(pin),
        .status_lamp_drive_n_o(lamp_o), .status_lamp_drive_n_oe(lamp_oe));
    dalc_led_model dalc_led_model_inst (
        .drive_o(lamp_o), .drive_oe(lamp_oe), .pin(pin), .lit(lit));

    // 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // new drive condition, returns just after the edge that takes it
    task automatic set_drv(input dalc_spin_t s, input logic c,
                           input logic f);
        @(posedge core_clk);
        drv.spindle <= s;
        drv.cmd_active <= c;
        drv.format_active <= f;
        @(posedge core_clk);
    endtask

    // one cylinder change pulse, lamp judged after it lands
    task automatic cyl_pulse();
        @(posedge core_clk);
        drv.cyl_change <= 1'b1;
        @(posedge core_clk);
        drv.cyl_change <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_and_map();
        apb(1'b0, `DALC_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, `DALC_OFS_TOGGLES, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, 12'h010, 32'h0000_0001);
        `CHK(err, 1'b1)
        // an unmapped write must leave the meaning bit alone
        apb(1'b0, `DALC_OFS_CTRL, 32'h0);
        `CHK({err, rd}, {1'b0, 32'h0})
        apb(1'b0, 12'h00C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        `CHK(lit, 1'b0)
    endtask

    // every sense, spindle and activity pairing of the table
    task automatic t_table();
        logic s, c, e;
        dalc_spin_t sp;
        for (int i = 0; i < 8; i++) begin
            s = i[2];
            sp = i[1] ? spin_at_speed : spin_stopped;
            c = i[0];
            e = (sp == spin_stopped) ? c : (c ~^ s);
            apb(1'b1, `DALC_OFS_CTRL, {31'h0, s});
            apb(1'b0, `DALC_OFS_CTRL, 32'h0);
            `CHK(rd[0], s)
            set_drv(sp, c, 1'b0);
            @(negedge core_clk);
            `CHK(lit, e)
            `CHK({lamp_oe, lamp_o}, {e, 1'b0})
            // pin readback passes a two-flop synchroniser first
            repeat (2) @(posedge core_clk);
            apb(1'b0, `DALC_OFS_STATUS, 32'h0);
            `CHK(rd[6:0], {1'b1, 1'b0, c, sp, e, e})
        end
    endtask

    // spin-up and spin-down blink, with command and format pending
    task automatic t_blink();
        int ones, flips;
        logic prev;
        for (int k = 0; k < 2; k++) begin
            set_drv(spin_stopped, 1'b0, 1'b0);
            set_drv(k ? spin_going_down : spin_going_up, 1'b1, 1'b1);
            ones = 0;
            flips = 0;
            prev = 1'b1;
            for (int i = 0; i < 4 * HALF; i++) begin
                @(negedge core_clk);
                if (i == 0) begin
                    `CHK(lit, 1'b1)
                end
                if (lit === 1'b1) ones++;
                if (lit !== prev) flips++;
                prev = lit;
                // one cylinder change pulse; the spin blink ignores it
                if (i == HALF || i == HALF + 1) begin
                    @(posedge core_clk);
                    drv.cyl_change <= (i == HALF);
                end
            end
            `CHK(ones, 2 * HALF)
            `CHK(flips, 3)
        end
        apb(1'b0, `DALC_OFS_TOGGLES, 32'h0);
        `CHK(rd, 32'h0000_0000)
    endtask

    // format holds the level and inverts per cylinder change
    task automatic t_format();
        apb(1'b1, `DALC_OFS_CTRL, 32'h0);
        set_drv(spin_at_speed, 1'b0, 1'b0);
        cyl_pulse();
        `CHK(lit, 1'b1)
        set_drv(spin_at_speed, 1'b1, 1'b1);
        @(negedge core_clk);
        `CHK(lit, 1'b1)
        for (int i = 0; i < 3; i++) begin
            cyl_pulse();
            `CHK(lit, i[0])
        end
        apb(1'b0, `DALC_OFS_TOGGLES, 32'h0);
        `CHK(rd, 32'h0000_0003)
    endtask

    // reset in mid-run clears the meaning bit, the count and the lamp
    task automatic t_mid_reset();
        apb(1'b1, `DALC_OFS_CTRL, 32'h0000_0001);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, `DALC_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, `DALC_OFS_TOGGLES, 32'h0);
        `CHK(rd, 32'h0000_0000)
        @(negedge core_clk);
        `CHK({lit, lamp_oe}, 2'b00)
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_reset_and_map();
        t_table();
        t_blink();
        t_format();
        t_mid_reset();
        end_sim();
    end

    // the tests need well under 1000 cycles
    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end
endmodule // tb
